// *** hdl/fxio_flex_port.sv ***
/*
 Half-duplex flexible data port: straps, mode resolution, bus steering,
 latch clock. Assumes pins are asynchronous to ref_clk and the converter
 sample clock is a slow pin sampled here; serial settings are plain ports.
*/
// Functional notes
// - Parallel half-duplex: both buses output when direction low, input when high.
// - Transmit interpolation one, two or four, from straps or serial settings.
// - Parallel transmit takes channel A from upper, B from lower together.
// - Receive converter clock reduced by a programmable divider.
// - Receive drives channel A on lower bus, channel B on upper bus; interleaved sends both on the lower bus.
// - One latch clock output follows whichever path is enabled.
// - Clone mode reachable only through serial settings, never straps.
// - Clone: 20-bit receive word, interleaved 10-bit transmit words.
// - Clone needs two or four times interpolation, never one.
// - Marker high steers to channel A, low to channel B.
// - Clone transmit: one latch clock rising edge per sample.
// - Clone receive: one pair of samples per latch clock cycle.
// - Straps captured on the reset pin rising edge, then held.
// - Receive power-down gates receive clocks and analog circuits.
// - Transmit power-down gates transmit clocks; latch clock keeps running.
// - Low-power strap high selects reduced converter power.
// - Chip-select high at reset enables serial settings, low keeps straps.
// - Without serial settings, duplex strap low selects half duplex.
// - Width strap low selects parallel 20-bit mode.
// - Interpolation straps: 00 one, 01 two, 10 four times.
// - Width strap high selects interleaved 10-bit mode.
// - Chip-select low at reset turns serial pins into strap inputs.
`timescale 1ns/10ps
`default_nettype none
module fxio_flex_port
   import fxio_pkg::*;
#(
   parameter int W = FXIO_W
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // Pins and straps
   input wire logic reset_n_pin,
   input wire logic conv_clk_pin,
   input wire logic direction_select_pin,
   input wire logic width_select_pin,
   input wire logic serial_cs_pin,
   input wire logic duplex_select_strap,
   input wire logic interp_factor_bit0,
   input wire logic interp_factor_bit1,
   input wire logic converter_low_power_strap,
   input wire logic rx_power_down_in,
   input wire logic tx_power_down_in,
   // Data buses
   input wire logic [W-1:0] upper_bus_in,
   output logic [W-1:0] upper_bus_out,
   output logic [W-1:0] upper_bus_oe_n,
   input wire logic [W-1:0] lower_bus_in,
   output logic [W-1:0] lower_bus_out,
   output logic [W-1:0] lower_bus_oe_n,
   output logic latch_clock_out_pin,
   // Serial settings
   input wire logic cfg_full_duplex,
   input wire logic cfg_width10,
   input wire logic cfg_clone,
   input wire logic [1:0] cfg_interp,
   input wire logic cfg_out_clk_off,
   input wire logic [FXIO_DIV_W-1:0] cfg_rx_clk_div,
   // Receive samples
   input wire logic [W-1:0] rx_a_data,
   input wire logic [W-1:0] rx_b_data,
   input wire logic rx_valid,
   output logic rx_ready,
   // Transmit samples
   output logic [W-1:0] tx_a_data,
   output logic [W-1:0] tx_b_data,
   output logic tx_valid,
   // Status
   output logic [1:0] active_mode,
   output logic [1:0] interp_factor,
   output logic low_power_mode,
   output logic serial_port_enable,
   output logic cfg_error,
   output logic rx_clk_gate_off,
   output logic rx_analog_off,
   output logic tx_clk_gate_off
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   // ************
   // Pin synchronisers
   // ************
   logic [FXIO_PIN_W-1:0] pin_vec, pin_s1_r, pin_s2_r;
   logic [W-1:0] up_s1_r, up_s2_r, lo_s1_r, lo_s2_r;

   always_comb begin
      pin_vec = '0;
      pin_vec[FXIO_PIN_RST] = reset_n_pin;
      pin_vec[FXIO_PIN_CONV] = conv_clk_pin;
      pin_vec[FXIO_PIN_DIR] = direction_select_pin;
      pin_vec[FXIO_PIN_WID] = width_select_pin;
      pin_vec[FXIO_PIN_CS] = serial_cs_pin;
      pin_vec[FXIO_PIN_DUP] = duplex_select_strap;
      pin_vec[FXIO_PIN_I0] = interp_factor_bit0;
      pin_vec[FXIO_PIN_I1] = interp_factor_bit1;
      pin_vec[FXIO_PIN_LP] = converter_low_power_strap;
      pin_vec[FXIO_PIN_RXPD] = rx_power_down_in;
      pin_vec[FXIO_PIN_TXPD] = tx_power_down_in;
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         pin_s1_r <= '0;
         pin_s2_r <= '0;
         up_s1_r <= '0;
         up_s2_r <= '0;
         lo_s1_r <= '0;
         lo_s2_r <= '0;
      end else begin
         pin_s1_r <= pin_vec;
         pin_s2_r <= pin_s1_r;
         up_s1_r <= upper_bus_in;
         up_s2_r <= up_s1_r;
         lo_s1_r <= lower_bus_in;
         lo_s2_r <= lo_s1_r;
      end
   end

   // ************
   // Edge detection
   // ************
   logic conv_d_r, rst_d_r;
   logic conv_rise, conv_fall, rst_rise, run, tx_dir, rxpd, txpd;

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         conv_d_r <= 1'b0;
         rst_d_r <= 1'b0;
      end else begin
         conv_d_r <= pin_s2_r[FXIO_PIN_CONV];
         rst_d_r <= pin_s2_r[FXIO_PIN_RST];
      end
   end

   assign conv_rise = pin_s2_r[FXIO_PIN_CONV] & ~conv_d_r;
   assign conv_fall = ~pin_s2_r[FXIO_PIN_CONV] & conv_d_r;
   assign rst_rise = pin_s2_r[FXIO_PIN_RST] & ~rst_d_r;
   assign run = pin_s2_r[FXIO_PIN_RST];
   assign tx_dir = pin_s2_r[FXIO_PIN_DIR];
   assign rxpd = pin_s2_r[FXIO_PIN_RXPD];
   assign txpd = pin_s2_r[FXIO_PIN_TXPD];

   // ************
   // Strap capture
   // ************
   logic cs_r, cs_nxt, dup_r, dup_nxt, wid_r, wid_nxt, lp_r, lp_nxt;
   logic [1:0] istrap_r, istrap_nxt;

   always_comb begin
      cs_nxt = cs_r;
      dup_nxt = dup_r;
      wid_nxt = wid_r;
      lp_nxt = lp_r;
      istrap_nxt = istrap_r;
      if (rst_rise) begin
         cs_nxt = pin_s2_r[FXIO_PIN_CS];
         dup_nxt = pin_s2_r[FXIO_PIN_DUP];
         wid_nxt = pin_s2_r[FXIO_PIN_WID];
         lp_nxt = pin_s2_r[FXIO_PIN_LP];
         istrap_nxt = {pin_s2_r[FXIO_PIN_I1], pin_s2_r[FXIO_PIN_I0]};
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         cs_r <= 1'b0;
         dup_r <= 1'b0;
         wid_r <= 1'b0;
         lp_r <= 1'b0;
         istrap_r <= FXIO_INTERP_1X;
      end else begin
         cs_r <= cs_nxt;
         dup_r <= dup_nxt;
         wid_r <= wid_nxt;
         lp_r <= lp_nxt;
         istrap_r <= istrap_nxt;
      end
   end

   // ************
   // Mode resolution and status
   // ************
   fxio_mode_e mode_r, mode_nxt;
   logic [1:0] interp_r, interp_nxt;
   logic err_r, err_nxt, rxg_r, rxg_nxt, txg_r, txg_nxt;

   always_comb begin
      err_nxt = 1'b0;
      if (cs_r) begin
         interp_nxt = cfg_interp;
         if (cfg_clone) begin
            mode_nxt = FXIO_CLONE;
         end else if (cfg_full_duplex) begin
            mode_nxt = FXIO_FULL_DUPLEX;
         end else begin
            mode_nxt = cfg_width10 ? FXIO_HALF_DUPLEX_INTERLEAVED
                                   : FXIO_HALF_DUPLEX_PARALLEL;
         end
      end else begin
         interp_nxt = istrap_r;
         if (dup_r) begin
            mode_nxt = FXIO_FULL_DUPLEX;
         end else begin
            mode_nxt = wid_r ? FXIO_HALF_DUPLEX_INTERLEAVED
                             : FXIO_HALF_DUPLEX_PARALLEL;
         end
      end
      // reserved code falls back to one times
      if (interp_nxt == 2'h3) begin
         interp_nxt = FXIO_INTERP_1X;
         err_nxt = 1'b1;
      end
      if (mode_nxt != FXIO_HALF_DUPLEX_PARALLEL && interp_nxt == FXIO_INTERP_1X) begin
         interp_nxt = FXIO_INTERP_2X;
         err_nxt = 1'b1;
      end
      rxg_nxt = ~run | rxpd | (tx_dir & (mode_r != FXIO_FULL_DUPLEX));
      txg_nxt = ~run | txpd | (~tx_dir & (mode_r != FXIO_FULL_DUPLEX));
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         mode_r <= FXIO_HALF_DUPLEX_PARALLEL;
         interp_r <= FXIO_INTERP_1X;
         err_r <= 1'b0;
         rxg_r <= 1'b1;
         txg_r <= 1'b1;
      end else begin
         mode_r <= mode_nxt;
         interp_r <= interp_nxt;
         err_r <= err_nxt;
         rxg_r <= rxg_nxt;
         txg_r <= txg_nxt;
      end
   end

   assign active_mode = mode_r;
   assign interp_factor = interp_r;
   assign cfg_error = err_r;
   assign serial_port_enable = cs_r;
   assign low_power_mode = lp_r;
   assign rx_clk_gate_off = rxg_r;
   assign tx_clk_gate_off = txg_r;
   assign rx_analog_off = pin_s2_r[FXIO_PIN_RXPD];

   // ************
   // Receive path
   // ************
   logic [2*W-1:0] buf_data;
   logic buf_valid, buf_pop, rx_act, rx_tick, rx_word, half_dup;
   logic [FXIO_DIV_W-1:0] div_cnt_r, div_cnt_nxt, div_lim;
   fxio_phase_e ph_r, ph_nxt;
   logic [W-1:0] up_out_r, up_out_nxt, lo_out_r, lo_out_nxt;
   logic [W-1:0] up_oe_r, up_oe_nxt, lo_oe_r, lo_oe_nxt;

   // Stall from the drain side holds the word, so no sample is lost
   fxio_pair_buf #(.WIDTH(2*W)) u_buf (
      .clk(ref_clk),
      .srst(srst),
      .in_data({rx_b_data, rx_a_data}),
      .in_valid(rx_valid),
      .in_ready(rx_ready),
      .out_data(buf_data),
      .out_valid(buf_valid),
      .out_ready(buf_pop)
   );

   assign half_dup = run & (mode_r != FXIO_FULL_DUPLEX);
   assign rx_act = half_dup & ~tx_dir & ~rxpd;
   assign div_lim = cs_r ? cfg_rx_clk_div : FXIO_DIV_RST;
   assign rx_tick = rx_act & conv_rise & (div_cnt_r == div_lim);
   assign rx_word = rx_tick & buf_valid;
   assign buf_pop = rx_word & ((mode_r != FXIO_HALF_DUPLEX_INTERLEAVED) | (ph_r == FXIO_PH_B));

   always_comb begin
      div_cnt_nxt = div_cnt_r;
      ph_nxt = ph_r;
      up_out_nxt = up_out_r;
      lo_out_nxt = lo_out_r;
      up_oe_nxt = FXIO_ALL_ONES;
      lo_oe_nxt = FXIO_ALL_ONES;
      if (!rx_act) begin
         div_cnt_nxt = FXIO_DIV_RST;
         ph_nxt = FXIO_PH_A;
      end else begin
         if (conv_rise) begin
            div_cnt_nxt = rx_tick ? FXIO_DIV_RST : div_cnt_r + 1'b1;
         end
         // buses turn to outputs in receive; when interleaved, only the MSB of the upper bus
         lo_oe_nxt = FXIO_ZERO;
         up_oe_nxt = (mode_r == FXIO_HALF_DUPLEX_INTERLEAVED) ? ~FXIO_MSB_MASK : FXIO_ZERO;
      end
      if (rx_word) begin
         case (mode_r)
            FXIO_HALF_DUPLEX_INTERLEAVED: begin
               // Sync bit on upper MSB marks channel B
               if (ph_r == FXIO_PH_A) begin
                  lo_out_nxt = buf_data[W-1:0];
                  up_out_nxt = FXIO_ZERO;
                  ph_nxt = FXIO_PH_B;
               end else begin
                  lo_out_nxt = buf_data[2*W-1:W];
                  up_out_nxt = FXIO_MSB_MASK;
                  ph_nxt = FXIO_PH_A;
               end
            end
            default: begin
               lo_out_nxt = buf_data[W-1:0];
               up_out_nxt = buf_data[2*W-1:W];
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         div_cnt_r <= FXIO_DIV_RST;
         ph_r <= FXIO_PH_A;
         up_out_r <= FXIO_ZERO;
         lo_out_r <= FXIO_ZERO;
         up_oe_r <= FXIO_ALL_ONES;
         lo_oe_r <= FXIO_ALL_ONES;
      end else begin
         div_cnt_r <= div_cnt_nxt;
         ph_r <= ph_nxt;
         up_out_r <= up_out_nxt;
         lo_out_r <= lo_out_nxt;
         up_oe_r <= up_oe_nxt;
         lo_oe_r <= lo_oe_nxt;
      end
   end

   assign upper_bus_out = up_out_r;
   assign lower_bus_out = lo_out_r;
   assign upper_bus_oe_n = up_oe_r;
   assign lower_bus_oe_n = lo_oe_r;

   // ************
   // Transmit path
   // ************
   logic tx_act, tx_tick, tx_channel_marker;
   logic [W-1:0] a_hold_r, a_hold_nxt, tx_a_r, tx_a_nxt, tx_b_r, tx_b_nxt;
   logic have_a_r, have_a_nxt, tx_vld_r, tx_vld_nxt;

   assign tx_act = half_dup & tx_dir & ~txpd;
   assign tx_tick = tx_act & conv_rise;
   assign tx_channel_marker = lo_s2_r[W-1];

   always_comb begin
      a_hold_nxt = a_hold_r;
      have_a_nxt = have_a_r & tx_act;
      tx_a_nxt = tx_a_r;
      tx_b_nxt = tx_b_r;
      tx_vld_nxt = 1'b0;
      if (tx_tick) begin
         case (mode_r)
            FXIO_HALF_DUPLEX_PARALLEL: begin
               tx_a_nxt = up_s2_r;
               tx_b_nxt = lo_s2_r;
               tx_vld_nxt = 1'b1;
            end
            default: begin
               if (tx_channel_marker) begin
                  a_hold_nxt = up_s2_r;
                  have_a_nxt = 1'b1;
               end else if (have_a_r) begin
                  tx_a_nxt = a_hold_r;
                  tx_b_nxt = up_s2_r;
                  tx_vld_nxt = 1'b1;
                  have_a_nxt = 1'b0;
               end
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         a_hold_r <= FXIO_ZERO;
         have_a_r <= 1'b0;
         tx_a_r <= FXIO_ZERO;
         tx_b_r <= FXIO_ZERO;
         tx_vld_r <= 1'b0;
      end else begin
         a_hold_r <= a_hold_nxt;
         have_a_r <= have_a_nxt;
         tx_a_r <= tx_a_nxt;
         tx_b_r <= tx_b_nxt;
         tx_vld_r <= tx_vld_nxt;
      end
   end

   assign tx_a_data = tx_a_r;
   assign tx_b_data = tx_b_r;
   assign tx_valid = tx_vld_r;

   // ************
   // Latch clock
   // ************
   logic lclk_r, lclk_nxt, lclk_set, tx_clk_run;

   // Keeps running through transmit power-down unless switched off
   assign tx_clk_run = half_dup & tx_dir & ~(cs_r & cfg_out_clk_off);
   // one rise per word or sample
   assign lclk_set = rx_word | (conv_rise & tx_clk_run);

   always_comb begin
      lclk_nxt = lclk_r;
      if (!half_dup) begin
         lclk_nxt = 1'b0;
      end else if (lclk_set) begin
         lclk_nxt = 1'b1;
      end else if (conv_fall) begin
         lclk_nxt = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         lclk_r <= 1'b0;
      end else begin
         lclk_r <= lclk_nxt;
      end
   end

   assign latch_clock_out_pin = lclk_r;

   // ************
   // Assertions
   // ************
   a_tx_bus_release: assert property ($past(tx_dir) && !$past(srst)
      |-> (&upper_bus_oe_n) && (&lower_bus_oe_n)) else $error("bus driven in transmit");
   a_rx_pair_lanes: assert property ((buf_pop && mode_r == FXIO_HALF_DUPLEX_PARALLEL)
      |=> lower_bus_out == $past(buf_data[W-1:0])
          && upper_bus_out == $past(buf_data[2*W-1:W])) else $error("receive lanes swapped");
   a_tx_concurrent: assert property ((tx_tick && mode_r == FXIO_HALF_DUPLEX_PARALLEL)
      |=> tx_valid && tx_a_data == $past(up_s2_r) && tx_b_data == $past(lo_s2_r))
      else $error("parallel transmit capture wrong");
   a_tx_marker_b: assert property ((tx_tick && mode_r != FXIO_HALF_DUPLEX_PARALLEL
      && !tx_channel_marker && have_a_r) |=> tx_valid && tx_b_data == $past(up_s2_r))
      else $error("channel B sample misrouted");
   a_lclk_cause: assert property ($rose(latch_clock_out_pin) |-> $past(lclk_set))
      else $error("latch clock rose without a transfer");
   a_lclk_follow: assert property (lclk_set && half_dup |=> latch_clock_out_pin)
      else $error("latch clock missed a transfer");
   a_clone_interp: assert property (mode_r == FXIO_CLONE |-> interp_r != FXIO_INTERP_1X)
      else $error("clone mode at one times");
   a_clone_serial: assert property (!cs_r |=> mode_r != FXIO_CLONE)
      else $error("clone mode from straps");
   a_strap_held: assert property (!rst_rise |=> $stable(wid_r) && $stable(dup_r)
      && $stable(istrap_r) && $stable(cs_r)) else $error("strap changed after capture");
   a_rxpd_gate: assert property (rxpd |-> !buf_pop ##1 rx_clk_gate_off)
      else $error("receive active in power-down");
   c_clone_rx: cover property (buf_pop && mode_r == FXIO_CLONE);
   c_interleaved_tx: cover property (tx_valid && mode_r != FXIO_HALF_DUPLEX_PARALLEL);
   c_parallel_tx: cover property (tx_valid && mode_r == FXIO_HALF_DUPLEX_PARALLEL);
   c_strap_capture: cover property (rst_rise ##1 !cs_r);
endmodule // fxio_flex_port
`default_nettype wire

// *** hdl/fxio_pair_buf.sv ***
/*
 Two-entry valid/ready buffer for receive sample pairs.
 Assumes producer and consumer on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module fxio_pair_buf #(
   parameter int WIDTH = 20
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Fill side
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   // Drain side
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   logic [WIDTH-1:0] mem_r [2];
   logic [WIDTH-1:0] mem_nxt [2];
   logic wr_r, wr_nxt, rd_r, rd_nxt;
   logic [1:0] cnt_r, cnt_nxt;
   logic push, pop;

   assign in_ready = (cnt_r != 2'h2);
   assign out_valid = (cnt_r != 2'h0);
   assign out_data = mem_r[rd_r];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_comb begin
      mem_nxt = mem_r;
      wr_nxt = wr_r;
      rd_nxt = rd_r;
      cnt_nxt = cnt_r;
      if (push) begin
         mem_nxt[wr_r] = in_data;
         wr_nxt = ~wr_r;
      end
      if (pop) begin
         rd_nxt = ~rd_r;
      end
      if (push && !pop) begin
         cnt_nxt = cnt_r + 2'h1;
      end else if (pop && !push) begin
         cnt_nxt = cnt_r - 2'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         mem_r[0] <= '0;
         mem_r[1] <= '0;
         wr_r <= 1'b0;
         rd_r <= 1'b0;
         cnt_r <= 2'h0;
      end else begin
         mem_r <= mem_nxt;
         wr_r <= wr_nxt;
         rd_r <= rd_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   a_buf_no_overfill: assert property (@(posedge clk) disable iff (srst)
      (cnt_r == 2'h2) && !out_ready |=> (cnt_r == 2'h2) && $stable(out_data))
      else $error("full buffer lost or changed a word");
endmodule // fxio_pair_buf
`default_nettype wire

// *** hdl/fxio_pkg.sv ***
/*
 Constants, pin indices and mode codes of the flexible data port.
 Assumes a single 50 MHz core clock; all other rates are enables.
*/
package fxio_pkg;
   // ************
   // Data widths
   // ************
   localparam int FXIO_W = 10;
   localparam logic [9:0] FXIO_MSB_MASK = 10'h200;
   localparam logic [9:0] FXIO_ALL_ONES = 10'h3ff;
   localparam logic [9:0] FXIO_ZERO = 10'h000;

   // ************
   // Bus modes
   // ************
   typedef enum logic [1:0] {
      FXIO_HALF_DUPLEX_PARALLEL = 2'b00,
      FXIO_HALF_DUPLEX_INTERLEAVED = 2'b01,
      FXIO_CLONE = 2'b10,
      FXIO_FULL_DUPLEX = 2'b11
   } fxio_mode_e;

   // Word phase of the interleaved receive output
   typedef enum logic {
      FXIO_PH_A = 1'b0,
      FXIO_PH_B = 1'b1
   } fxio_phase_e;

   // ************
   // Interpolation codes
   // ************
   localparam logic [1:0] FXIO_INTERP_1X = 2'h0;
   localparam logic [1:0] FXIO_INTERP_2X = 2'h1;
   localparam logic [1:0] FXIO_INTERP_4X = 2'h2;

   // ************
   // Synchronised pin indices
   // ************
   localparam int FXIO_PIN_RST = 0;
   localparam int FXIO_PIN_CONV = 1;
   localparam int FXIO_PIN_DIR = 2;
   localparam int FXIO_PIN_WID = 3;
   localparam int FXIO_PIN_CS = 4;
   localparam int FXIO_PIN_DUP = 5;
   localparam int FXIO_PIN_I0 = 6;
   localparam int FXIO_PIN_I1 = 7;
   localparam int FXIO_PIN_LP = 8;
   localparam int FXIO_PIN_RXPD = 9;
   localparam int FXIO_PIN_TXPD = 10;
   localparam int FXIO_PIN_W = 11;

   // Receive clock divider
   localparam int FXIO_DIV_W = 4;
   localparam logic [3:0] FXIO_DIV_RST = 4'h0;
endpackage

// *** tb/fxio_host_model.sv ***
/* Host side of the data buses: resolves both buses from device and host drive.
   Assumes the bench raises hen only while the port is in transmit. */
`timescale 1ns/10ps
`default_nettype none
module fxio_host_model (
   // Clock
   input wire logic clk,
   // Host side
   input wire logic hen,
   input wire logic [9:0] ud,
   input wire logic [9:0] ld,
   // Device side
   input wire logic [9:0] uo,
   input wire logic [9:0] uoe,
   input wire logic [9:0] lo,
   input wire logic [9:0] loe,
   // Resolved wires
   output logic [9:0] uw,
   output logic [9:0] lw
);
   logic [9:0] ul_r = '0;
   logic [9:0] ll_r = '0;
   // ************
   // Resolution
   // ************
   // Device drive wins; host drives only while hen is high
   always_comb begin
      for (int i = 0; i < 10; i++) begin
         uw[i] = !uoe[i] ? uo[i] : (hen ? ud[i] : ~ul_r[i]);
         lw[i] = !loe[i] ? lo[i] : (hen ? ld[i] : ~ll_r[i]);
      end
   end
   // Undriven bits toggle so a stale level never passes for data
   always_ff @(posedge clk) begin
      ul_r <= uw;
      ll_r <= lw;
   end
endmodule // fxio_host_model
`default_nettype wire

// *** tb/testbench.sv ***
/* Bench of the flexible data port: straps, receive buffering, transmit steering.
   Assumes fxio_pkg and the host bus model are compiled first. */
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import fxio_pkg::*;
   logic ref_clk = '0, srst = '1, rst_n = '0, conv = '0, dir = '0, wid = '0, cs = '0;
   logic dup = '0, lp = '0, rpd = '0, tpd = '0, cfd = '0, cw = '0, ccl = '0, coff = '0;
   logic rv = '0, hen = '0, lclk, rr, tv, lpm, spe, cerr, rgo, rao, tgo;
   logic [1:0] ip = '0, ci = '0, am, ifa;
   logic [3:0] cdiv = '0;
   logic [9:0] ra = '0, rb = '0, ud = '0, ld = '0, uw, lw, uo, uoe, lo, loe, ta, tb;
   logic [2:0] tbl [4] = '{3'h0, 3'h1, 3'h2, 3'h5};
   int bad_count = 0, n_checks = 0, cyc = 0;

   always #10 ref_clk = ~ref_clk;
   initial begin
      #7;
      forever #80 conv = ~conv;
   end

   fxio_flex_port dut (.ref_clk(ref_clk), .srst(srst), .reset_n_pin(rst_n),
      .conv_clk_pin(conv), .direction_select_pin(dir), .width_select_pin(wid),
      .serial_cs_pin(cs), .duplex_select_strap(dup), .interp_factor_bit0(ip[0]),
      .interp_factor_bit1(ip[1]), .converter_low_power_strap(lp),
      .rx_power_down_in(rpd), .tx_power_down_in(tpd), .upper_bus_in(uw),
      .upper_bus_out(uo), .upper_bus_oe_n(uoe), .lower_bus_in(lw), .lower_bus_out(lo),
      .lower_bus_oe_n(loe), .latch_clock_out_pin(lclk), .cfg_full_duplex(cfd),
      .cfg_width10(cw), .cfg_clone(ccl), .cfg_interp(ci), .cfg_out_clk_off(coff),
      .cfg_rx_clk_div(cdiv), .rx_a_data(ra), .rx_b_data(rb), .rx_valid(rv),
      .rx_ready(rr), .tx_a_data(ta), .tx_b_data(tb), .tx_valid(tv), .active_mode(am),
      .interp_factor(ifa), .low_power_mode(lpm), .serial_port_enable(spe),
      .cfg_error(cerr), .rx_clk_gate_off(rgo), .rx_analog_off(rao),
      .tx_clk_gate_off(tgo));
   fxio_host_model host (.clk(ref_clk), .hen(hen), .ud(ud), .ld(ld), .uo(uo),
      .uoe(uoe), .lo(lo), .loe(loe), .uw(uw), .lw(lw));

   // ************
   // Tasks
   // ************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Straps flip after capture so that only the captured copy can pass
   task automatic boot(input logic c, input logic w, input logic [1:0] i, input logic l);
      @(negedge ref_clk);
      srst = '1; rst_n = '0; cs = c; dup = '0; wid = w; ip = i; lp = l;
      repeat (12) @(negedge ref_clk);
      srst = '0;
      repeat (2) @(negedge ref_clk);
      rst_n = '1;
      repeat (8) @(negedge ref_clk);
      {cs, dup, wid, ip, lp} = ~{c, 1'h0, w, i, l};
      repeat (3) @(negedge ref_clk);
   endtask
   task automatic wait_tx;
      for (int k = 0; k < 100 && tv !== 1'h1; k++) @(negedge ref_clk);
   endtask
   task automatic wait_rise;
      for (int k = 0; k < 100 && lclk !== 1'h0; k++) @(negedge ref_clk);
      for (int k = 0; k < 100 && lclk !== 1'h1; k++) @(negedge ref_clk);
   endtask
   task automatic tx_put(input logic [9:0] u, input logic [9:0] l);
      @(negedge conv);
      @(negedge ref_clk);
      ud = u; ld = l;
   endtask
   // Fill while powered down, check refusal, then drain to empty
   task automatic rx_run(input logic [9:0] b);
      rpd = '1;
      repeat (6) @(negedge ref_clk);
      chk({rgo, rao}, 20'h3); // gates while down
      rv = '1;
      for (int k = 0; k < 3; k++) begin
         ra = b + 10'(k); rb = ~ra;
         if (k == 2) chk(rr, 20'h0); // third word refused
         @(negedge ref_clk);
      end
      rv = '0;
      @(negedge conv);
      @(negedge ref_clk);
      rpd = '0;
      // Third word was refused, so the second one stands and no edge follows
      for (int k = 0; k < 3; k++) begin
         wait_rise();
         chk({uo, lo}, {~(b + 10'(k > 0)), b + 10'(k > 0)}); // A low, B up
         chk({uoe, loe}, 20'h0); // outputs in receive
         if (k == 2) chk(lclk, 32'h0); // no word, no edge
      end
   endtask

   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         wrap_up();
      end
   end

   // ************
   // Tests
   // ************
   initial begin
      for (int i = 0; i < 4; i++) begin
         boot(1'h0, tbl[i][2], tbl[i][1:0], tbl[i][0]);
         chk({am, ifa, lpm, spe}, {1'h0, tbl[i][2], tbl[i][1:0], tbl[i][0], 1'h0});
      end
      $display("strap test done");
      boot(1'h0, 1'h0, 2'h1, 1'h0);
      rx_run(10'h155);
      dir = '1; hen = '1;
      repeat (6) @(negedge ref_clk);
      chk({tgo, uoe, loe}, 32'hfffff); // inputs in transmit, clocks on
      tx_put(10'h2a5, 10'h0c3);
      wait_tx();
      chk({tv, ta, tb}, {1'h1, 10'h2a5, 10'h0c3}); // upper is A
      tpd = '1;
      repeat (6) @(negedge ref_clk);
      chk(tgo, 32'h1); // transmit clocks gated
      wait_rise();
      chk({lclk, tv}, 32'h2); // latch clock runs, no capture
      tpd = '0;
      $display("parallel test done");
      ccl = '1;
      boot(1'h1, 1'h0, 2'h0, 1'h0);
      chk({am, ifa, cerr, spe}, 20'h27); // clone forced to 2x
      ci = 2'h2;
      repeat (4) @(negedge ref_clk);
      chk({ifa, cerr}, 20'h4); // serial 4x
      tx_put(10'h111, 10'h200);
      tx_put(10'h222, 10'h000);
      wait_tx();
      chk({tv, ta, tb}, {1'h1, 10'h111, 10'h222}); // marker steers
      hen = '0; dir = '0;
      cdiv = 4'h1;
      rx_run(10'h0f0);
      $display("clone test done");
      wrap_up();
   end
endmodule // testbench
`default_nettype wire
